// ===== rtl/cal_pkg.sv
// Constants and helpers shared by the calendar counters.
package cal_pkg;

    // Register offsets on the register port.
    localparam logic [7:0] CAL_ADDR_WEEKDAY = 8'h03;
    localparam logic [7:0] CAL_ADDR_DATE = 8'h04;
    localparam logic [7:0] CAL_ADDR_MONTH = 8'h05;
    localparam logic [7:0] CAL_ADDR_YEAR = 8'h06;

    // Field widths, all fields sit at bit 0 of their register.
    localparam int CAL_REG_W = 8;
    localparam int CAL_WEEKDAY_W = 3;
    localparam int CAL_DATE_W = 6;
    localparam int CAL_MONTH_W = 5;
    localparam int CAL_YEAR_W = 8;

    // Reset values.
    localparam logic [2:0] CAL_RST_WEEKDAY = 3'h0;
    localparam logic [5:0] CAL_RST_DATE = 6'h01;
    localparam logic [4:0] CAL_RST_MONTH = 5'h01;
    localparam logic [7:0] CAL_RST_YEAR = 8'h00;

    // Counter limits, BCD coded where the field is BCD.
    localparam logic [2:0] CAL_WEEKDAY_LAST = 3'h6;
    localparam logic [2:0] CAL_WEEKDAY_FIRST = 3'h0;
    localparam logic [5:0] CAL_DATE_FIRST = 6'h01;
    localparam logic [4:0] CAL_MONTH_FIRST = 5'h01;
    localparam logic [4:0] CAL_MONTH_LAST = 5'h12;
    localparam logic [7:0] CAL_YEAR_FIRST = 8'h00;
    localparam logic [7:0] CAL_YEAR_LAST = 8'h99;

    // Months that are not 31 days long.
    localparam logic [4:0] CAL_MON_FEB = 5'h02;
    localparam logic [4:0] CAL_MON_APR = 5'h04;
    localparam logic [4:0] CAL_MON_JUN = 5'h06;
    localparam logic [4:0] CAL_MON_SEP = 5'h09;
    localparam logic [4:0] CAL_MON_NOV = 5'h11;

    // Month lengths in BCD.
    localparam logic [5:0] CAL_DAYS_31 = 6'h31;
    localparam logic [5:0] CAL_DAYS_30 = 6'h30;
    localparam logic [5:0] CAL_DAYS_29 = 6'h29;
    localparam logic [5:0] CAL_DAYS_28 = 6'h28;

    // Unit digits of leap years within a decade.
    localparam logic [3:0] CAL_LEAP_EVEN_A = 4'h0;
    localparam logic [3:0] CAL_LEAP_EVEN_B = 4'h4;
    localparam logic [3:0] CAL_LEAP_EVEN_C = 4'h8;
    localparam logic [3:0] CAL_LEAP_ODD_A = 4'h2;
    localparam logic [3:0] CAL_LEAP_ODD_B = 4'h6;

    // Two-digit BCD increment; 99 steps to A0h, callers wrap earlier.
    function automatic logic [7:0] cal_bcd_inc(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        if (v[3:0] >= 4'h9) begin
            r = {v[7:4] + 4'h1, 4'h0};
        end else begin
            r = {v[7:4], v[3:0] + 4'h1};
        end
        return r;
    endfunction

endpackage

// ===== rtl/cal_month_len.sv
// Last day of a month for years 2000 to 2099.
`timescale 1ns/100ps
`default_nettype none

module cal_month_len
    import cal_pkg::*;
(
    input wire logic [4:0] month,
    input wire logic [7:0] year,
    output logic [5:0] lastDay
);

    wire logic evenTens;
    wire logic leapYear;
    wire logic thirtyDay;

    // Within 2000 to 2099 every year divisible by four is a leap year,
    // so 2000 counts as one and no century test is needed.
    assign evenTens = ~year[4];
    assign leapYear = evenTens ?
        (year[3:0] == CAL_LEAP_EVEN_A || year[3:0] == CAL_LEAP_EVEN_B ||
         year[3:0] == CAL_LEAP_EVEN_C) :
        (year[3:0] == CAL_LEAP_ODD_A || year[3:0] == CAL_LEAP_ODD_B); // (R5)

    assign thirtyDay = month == CAL_MON_APR || month == CAL_MON_JUN ||
        month == CAL_MON_SEP || month == CAL_MON_NOV;

    assign lastDay = (month == CAL_MON_FEB) ?
        (leapYear ? CAL_DAYS_29 : CAL_DAYS_28) :
        (thirtyDay ? CAL_DAYS_30 : CAL_DAYS_31); // (R5)

endmodule

`default_nettype wire

// ===== rtl/cal_calendar.sv
// Weekday, date, month and year counters with their register port.
//
// Overview of operation
// (R1) Weekday is a 3-bit counter stepping 0 to 6 per day, then wrapping.
// (R2) Weekday values carry no fixed meaning; software assigns the names.
// (R3) Weekday sits in bits 2:0, bits 7:3 read zero, resets to zero.
// (R4) Date holds BCD 01 to 31 in bits 5:0, upper bits zero, resets 01.
// (R5) Month lengths and 29 February are right for 2000 through 2099.
// (R6) Month holds BCD 01 to 12, bits 7:5 read zero, resets to 01.
// (R7) Month is BCD in bits 4:0, October to December are 10h to 12h.
// (R8) All calendar registers are readable at any time, lock or not.
// (R9) Calendar writes are dropped while password write protection is on.
// (R10) Year holds BCD 00 to 99, takes the month carry, resets to 00.
// (R11) Daily carry steps date; month end steps month; December steps year.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module cal_calendar
    import cal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [7:0] regRdData,
    input wire logic writeProtect,
    input wire logic dayCarry,
    output logic [2:0] weekdayVal,
    output logic [5:0] dateVal,
    output logic [4:0] monthVal,
    output logic [7:0] yearVal,
    output logic centuryCarry
);

    logic [2:0] weekday_ff;
    logic [5:0] date_ff;
    logic [4:0] month_ff;
    logic [7:0] year_ff;
    logic [7:0] regRdData_ff;
    logic centuryCarry_ff;

    logic [2:0] nxt_weekday;
    logic [5:0] nxt_date;
    logic [4:0] nxt_month;
    logic [7:0] nxt_year;
    logic [7:0] nxt_regRdData;
    logic nxt_centuryCarry;

    wire logic wrAllowed;
    wire logic wrWeekday;
    wire logic wrDate;
    wire logic wrMonth;
    wire logic wrYear;
    wire logic [5:0] lastDay;
    wire logic weekdayWrap;
    wire logic dateWrap;
    wire logic monthWrap;
    wire logic yearWrap;
    wire logic monthStep;
    wire logic yearStep;
    wire logic [7:0] dateInc;
    wire logic [7:0] monthInc;
    wire logic [7:0] yearInc;
    wire logic [2:0] weekdayInc;
    wire logic [7:0] rdValue;

    // Write decode. The lock input comes from the password logic on this
    // clock, so it is used directly and takes effect on the same strobe.
    assign wrAllowed = regWrStb & ~writeProtect; // (R9)
    assign wrWeekday = wrAllowed && regAddr == CAL_ADDR_WEEKDAY; // (R9)
    assign wrDate = wrAllowed && regAddr == CAL_ADDR_DATE; // (R9)
    assign wrMonth = wrAllowed && regAddr == CAL_ADDR_MONTH; // (R9)
    assign wrYear = wrAllowed && regAddr == CAL_ADDR_YEAR; // (R9)

    cal_month_len u_monthLen (
        .month(month_ff),
        .year(year_ff),
        .lastDay(lastDay)
    );

    // Wrap tests use >= so that an out-of-range value written by software
    // returns to the first value on the next step instead of running on.
    assign weekdayWrap = weekday_ff >= CAL_WEEKDAY_LAST; // (R1)
    assign dateWrap = date_ff >= lastDay; // (R11)
    assign monthWrap = month_ff >= CAL_MONTH_LAST; // (R11)
    assign yearWrap = year_ff >= CAL_YEAR_LAST; // (R10)

    // A counter written in the same cycle as its carry keeps the written
    // value, and its own carry onward is dropped for that day.
    assign monthStep = dayCarry & dateWrap & ~wrDate; // (R11)
    assign yearStep = monthStep & monthWrap & ~wrMonth; // (R11)

    assign weekdayInc = weekday_ff + 3'h1; // (R1)
    assign dateInc = cal_bcd_inc({2'h0, date_ff}); // (R4)
    assign monthInc = cal_bcd_inc({3'h0, month_ff}); // (R7)
    assign yearInc = cal_bcd_inc(year_ff); // (R10)

    // The weekday is a plain count; no day name is decoded from it.
    always_comb begin
        nxt_weekday = weekday_ff;
        if (wrWeekday) begin
            nxt_weekday = regWrData[CAL_WEEKDAY_W-1:0]; // (R2)
        end else if (dayCarry) begin
            nxt_weekday = weekdayWrap ? CAL_WEEKDAY_FIRST : weekdayInc; // (R1)
        end
    end

    always_comb begin
        nxt_date = date_ff;
        if (wrDate) begin
            nxt_date = regWrData[CAL_DATE_W-1:0]; // (R4)
        end else if (dayCarry) begin
            nxt_date = dateWrap ? CAL_DATE_FIRST : dateInc[5:0]; // (R11)
        end
    end

    always_comb begin
        nxt_month = month_ff;
        if (wrMonth) begin
            nxt_month = regWrData[CAL_MONTH_W-1:0]; // (R7)
        end else if (monthStep) begin
            nxt_month = monthWrap ? CAL_MONTH_FIRST : monthInc[4:0]; // (R11)
        end
    end

    always_comb begin
        nxt_year = year_ff;
        if (wrYear) begin
            nxt_year = regWrData[CAL_YEAR_W-1:0]; // (R10)
        end else if (yearStep) begin
            nxt_year = yearWrap ? CAL_YEAR_FIRST : yearInc; // (R10)
        end
    end

    assign nxt_centuryCarry = yearStep & yearWrap & ~wrYear;

    // Reads never look at the lock; unused upper bits are zero.
    assign rdValue =
        (regAddr == CAL_ADDR_WEEKDAY) ? {5'h00, weekday_ff} : // (R3)
        (regAddr == CAL_ADDR_DATE) ? {2'h0, date_ff} : // (R4)
        (regAddr == CAL_ADDR_MONTH) ? {3'h0, month_ff} : // (R6)
        (regAddr == CAL_ADDR_YEAR) ? year_ff : 8'h00; // (R8)

    // Read data stand for one cycle only, so the port returns to zero.
    assign nxt_regRdData = regRdStb ? rdValue : 8'h00; // (R8)

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            weekday_ff <= CAL_RST_WEEKDAY; // (R3)
            date_ff <= CAL_RST_DATE; // (R4)
            month_ff <= CAL_RST_MONTH; // (R6)
            year_ff <= CAL_RST_YEAR; // (R10)
        end else begin
            weekday_ff <= nxt_weekday;
            date_ff <= nxt_date;
            month_ff <= nxt_month;
            year_ff <= nxt_year;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            regRdData_ff <= 8'h00;
            centuryCarry_ff <= 1'b0;
        end else begin
            regRdData_ff <= nxt_regRdData;
            centuryCarry_ff <= nxt_centuryCarry;
        end
    end

    assign regRdData = regRdData_ff;
    assign weekdayVal = weekday_ff;
    assign dateVal = date_ff;
    assign monthVal = month_ff;
    assign yearVal = year_ff;
    assign centuryCarry = centuryCarry_ff;

endmodule

`default_nettype wire

// ===== verification/cal_calendar_props.sv
// Port-level assertions for the calendar counters.
`timescale 1ns/100ps
`default_nettype none
module cal_calendar_props
    import cal_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [7:0] regRdData,
    input wire logic writeProtect,
    input wire logic dayCarry,
    input wire logic [2:0] weekdayVal,
    input wire logic [5:0] dateVal,
    input wire logic [4:0] monthVal,
    input wire logic [7:0] yearVal,
    input wire logic centuryCarry
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic wrOk = regWrStb && !writeProtect;
    AST_WD_STEP: assert property (dayCarry && !(wrOk &&
        regAddr == CAL_ADDR_WEEKDAY) |=> weekdayVal == ($past(weekdayVal)
        >= CAL_WEEKDAY_LAST ? CAL_WEEKDAY_FIRST : $past(weekdayVal) + 3'h1))
        else $error("weekday step wrong");
    AST_LOCK_HOLD: assert property (regWrStb && writeProtect && !dayCarry
        |=> $stable({weekdayVal, dateVal, monthVal, yearVal}))
        else $error("locked write changed a counter");
    AST_RD_IDLE: assert property (!regRdStb |=> regRdData == 8'h00)
        else $error("read data not zero");
    AST_RD_WD: assert property (regRdStb && regAddr == CAL_ADDR_WEEKDAY
        |=> regRdData == {5'h00, $past(weekdayVal)}) else $error("rd wd");
    AST_RD_DATE: assert property (regRdStb && regAddr == CAL_ADDR_DATE
        |=> regRdData == {2'h0, $past(dateVal)}) else $error("rd date");
    AST_RD_MON: assert property (regRdStb && regAddr == CAL_ADDR_MONTH
        |=> regRdData == {3'h0, $past(monthVal)}) else $error("rd month");
    AST_WR_MON: assert property (wrOk && regAddr == CAL_ADDR_MONTH
        |=> {3'h0, monthVal} == ($past(regWrData) & 8'h1F))
        else $error("month write lost");
    AST_YEAR_END: assert property (dayCarry && !regWrStb &&
        dateVal == CAL_DAYS_31 && monthVal == CAL_MONTH_LAST
        |=> dateVal == CAL_DATE_FIRST && monthVal == CAL_MONTH_FIRST)
        else $error("year end wrap wrong");
    // A reset that clears year 99 must not look like a century step.
    AST_CENTURY: assert property (!$past(regWrStb) && !$past(reset) &&
        $past(yearVal) == CAL_YEAR_LAST && yearVal == CAL_YEAR_FIRST
        |-> ##[0:1] centuryCarry) else $error("century carry missing");
    cover property (centuryCarry);
    cover property (regWrStb && writeProtect);
    cover property (dayCarry && monthVal == CAL_MON_FEB && dateVal == 6'h29);
endmodule
bind cal_calendar cal_calendar_props cal_calendar_props_i (
    .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .writeProtect(writeProtect), .dayCarry(dayCarry),
    .weekdayVal(weekdayVal), .dateVal(dateVal), .monthVal(monthVal),
    .yearVal(yearVal), .centuryCarry(centuryCarry));
`default_nettype wire

// ===== verification/testbench.sv
// Self-checking bench for the calendar counters.
`timescale 1ns/100ps
`default_nettype none
module testbench
    import cal_pkg::*;
;
    logic clk_sys = 1'b0, reset = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
    logic writeProtect = 1'b0, dayCarry = 1'b0, rdLate = 1'b0, centuryCarry;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData, yearVal, y;
    logic [7:0] expV;
    logic [2:0] weekdayVal, wd;
    logic [5:0] dateVal, d;
    logic [4:0] monthVal, m;
    logic [7:0] expQ[$];
    logic [7:0] yrs[4] = '{8'h00, 8'h23, 8'h24, 8'h99};
    int n_fail = 0, compares = 0, cycles = 0, nCent = 0;
    logic [21:0] gotLvl, expLvl;
    cal_calendar cal_calendar_i (.clk_sys(clk_sys), .reset(reset),
        .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
        .regRdStb(regRdStb), .regRdData(regRdData),
        .writeProtect(writeProtect), .dayCarry(dayCarry),
        .weekdayVal(weekdayVal), .dateVal(dateVal), .monthVal(monthVal),
        .yearVal(yearVal), .centuryCarry(centuryCarry));
    initial forever #2.5 clk_sys = ~clk_sys;
    task automatic complete_run();
        if (n_fail == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Each task leaves one idle cycle, so no strobe is set twice in a step.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge clk_sys);
        regWrStb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        expQ.push_back(e);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge clk_sys);
        regRdStb <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic carry();
        dayCarry <= 1'b1;
        @(posedge clk_sys);
        dayCarry <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic checkAll();
        rd(CAL_ADDR_WEEKDAY, {5'h00, wd});
        rd(CAL_ADDR_DATE, {2'h0, d});
        rd(CAL_ADDR_MONTH, {3'h0, m});
        rd(CAL_ADDR_YEAR, y);
        // The counter outputs are quiet here, no carry or write is pending.
        gotLvl = {weekdayVal, dateVal, monthVal, yearVal};
        expLvl = {wd, d, m, y};
        compares++;
        if (gotLvl !== expLvl) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, gotLvl, expLvl);
        end
    endtask
    function automatic logic [7:0] inc(input logic [7:0] v);
        return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
    endfunction
    function automatic logic [5:0] monLen(input logic [4:0] mm,
        input logic [7:0] yy);
        if (mm == 5'h02) return ((yy[7:4] * 10 + yy[3:0]) % 4 == 0) ? 6'h29
            : 6'h28;
        if (mm == 5'h04 || mm == 5'h06 || mm == 5'h09 || mm == 5'h11)
            return 6'h30;
        return 6'h31;
    endfunction
    always @(posedge clk_sys) begin
        rdLate <= regRdStb;
        cycles++;
        if (centuryCarry) begin
            nCent++;
        end
        if (rdLate) begin
            expV = expQ.pop_front();
            compares++;
            if (regRdData !== expV) begin
                n_fail++;
                $display("ERROR %0t got %h exp %h", $time, regRdData, expV);
            end
        end
        if (cycles > 30000) begin
            n_fail++;
            complete_run();
        end
    end
    initial begin
        void'($urandom(32'h5144));
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        wd = 3'h0;
        d = 6'h01;
        m = 5'h01;
        y = 8'h00;
        checkAll();
        rd(8'h07, 8'h00);
        writeProtect <= 1'b1;
        wr(CAL_ADDR_MONTH, 8'h12);
        wr(CAL_ADDR_WEEKDAY, 8'hFD);
        writeProtect <= 1'b0;
        checkAll();
        // A full year per start value crosses every month end; the runs from 00 and 24 cross 29 February.
        foreach (yrs[i]) begin
            wd = 3'($urandom_range(6));
            y = yrs[i];
            m = 5'h01;
            d = 6'h01;
            wr(CAL_ADDR_WEEKDAY, {5'h1F, wd});
            wr(CAL_ADDR_DATE, 8'h01);
            wr(CAL_ADDR_MONTH, 8'h01);
            wr(CAL_ADDR_YEAR, y);
            repeat (366) begin
                carry();
                wd = (wd == 3'h6) ? 3'h0 : wd + 3'h1;
                if (d >= monLen(m, y)) begin
                    d = 6'h01;
                    if (m == 5'h12) begin
                        m = 5'h01;
                        y = (y == 8'h99) ? 8'h00 : inc(y);
                    end else m = 5'(inc({3'h0, m}));
                end else d = 6'(inc({2'h0, d}));
                checkAll();
            end
        end
        // A second reset in mid-run must bring every counter back.
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        wd = 3'h0;
        d = 6'h01;
        m = 5'h01;
        y = 8'h00;
        checkAll();
        // Only the run that starts in year 99 crosses the century once.
        compares++;
        if (nCent !== 1) begin
            n_fail++;
            $display("ERROR %0t got %h exp %h", $time, nCent, 1);
        end
        complete_run();
    end
endmodule
`default_nettype wire
